/* eep_cfg.svh */
// eep_cfg.svh: addresses, field positions and reset values of the eeprom block
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH
// device address preambles, upper nibble of the first byte
`define EEP_PRE_ARRAY  4'ha
`define EEP_PRE_EXT    4'hb
`define EEP_PRE_PROT   4'h6
// select codes of the protection commands, bits 3..1
`define EEP_SEL_REV    3'h1
`define EEP_SEL_CLR    3'h3
// extended block layout
`define EEP_SER_BASE   8'h80
`define EEP_SER_LAST   8'h8f
`define EEP_EUI64_BASE 8'h98
`define EEP_EUI48_BASE 8'h9a
`define EEP_EXT_LAST   8'h9f
// writable upper half while a protection flag is set
`define EEP_UPPER_BASE 8'h80
// data driven where the contents are undefined
`define EEP_UNDEF      8'hff
`define EEP_MEM_RST    8'hff
// bits per byte on the link
`define EEP_BITS       4'h8
// arbitrary seeds for the factory contents
`define EEP_SER_SEED   8'h5a
`define EEP_EUI_SEED   8'h3c
// register port offsets and fields
`define EEP_REG_STATUS 4'h0
`define EEP_REG_CTRL   4'h4
`define EEP_ST_PFLAG   0
`define EEP_ST_RFLAG   1
`define EEP_ST_WP      2
`define EEP_CTRL_V64   0
`define EEP_CTRL_RST   8'h00
`endif

/* eep_pkg.sv */
// eep_pkg: types of the eeprom block
package eep_pkg;
  typedef enum logic [3:0] {
    EEP_IDLE = 4'h0,
    EEP_ADDR = 4'h1,
    EEP_AACK = 4'h2,
    EEP_WORD = 4'h3,
    EEP_WACK = 4'h4,
    EEP_DATA = 4'h5,
    EEP_DACK = 4'h6,
    EEP_SEND = 4'h7,
    EEP_MACK = 4'h8
  } eep_state_e;

  typedef enum logic [1:0] {
    EEP_K_ARRAY = 2'h0,
    EEP_K_EXT   = 2'h1,
    EEP_K_PROT  = 2'h2
  } eep_kind_e;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] strap;
    logic       hv;
    logic       v64;
  } eep_pins_s;

  typedef struct packed {
    eep_state_e st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic       oe;
    eep_kind_e  kind;
    logic       rd;
    logic [7:0] ptr;
    logic       pflag;
    logic       rflag;
    logic       mack;
    logic       scl_q;
    logic       sda_q;
    logic       wr;
    logic [7:0] waddr;
    logic [7:0] wdat;
  } eep_link_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } eep_sys_s;
endpackage : eep_pkg

/* eep_sync.sv */
// eep_sync: two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module eep_sync #(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : eep_sync
`default_nettype wire

/* eep_store.sv */
// eep_store: 256-byte array and read-only extended block
`timescale 1ns/100ps
`default_nettype none
`include "eep_cfg.svh"
module eep_store
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdat_i,
  input  wire logic       ext_i,
  input  wire logic       v64_i,
  input  wire logic [7:0] addr_i,
  output logic      [7:0] rdat_o
);
  logic [7:0] mem [256];
  logic [7:0] ext_dat;
  logic [7:0] eui_base;

  // one flip-flop byte per array entry
  for (genvar i = 0; i < 256; i++)
  begin : g_mem
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        mem[i] <= `EEP_MEM_RST;
      else if (wr_i && waddr_i == 8'(i))
        mem[i] <= wdat_i;
    end
  end

  // factory contents, undefined outside serial and identifier ranges
  always_comb
  begin
    eui_base = v64_i ? `EEP_EUI64_BASE : `EEP_EUI48_BASE;
    ext_dat  = `EEP_UNDEF;
    if (addr_i >= `EEP_SER_BASE && addr_i <= `EEP_SER_LAST)
      ext_dat = `EEP_SER_SEED ^ addr_i;
    else if (addr_i >= eui_base && addr_i <= `EEP_EXT_LAST)
      ext_dat = `EEP_EUI_SEED ^ addr_i;
  end

  assign rdat_o = ext_i ? ext_dat : mem[addr_i];
endmodule : eep_store
`default_nettype wire

/* eep_top.sv */
// eep_top: two-wire eeprom slave with shared pointer and protection flags
// Functional notes
// - wp high: array commands acked, reads return data, writes change nothing
// - wp high: set command on unprogrammed flag acked, flag unchanged
// - wp high: clear-reversible acked if permanent flag clear, flags unchanged
// - set on programmed flag, or clear while permanent set, not acked
// - permanent query 0110+straps+read acked only while permanent flag clear
// - reversible query 0110+001+read acked only while reversible flag clear
// - pointer holds last accessed address plus one, kept between operations
// - array reads wrap from last byte to first byte and continue
// - current-address read sends byte at pointer; nack then stop ends it
// - sequential read continues while master acknowledges each byte
// - serial number at 80h in extended block, elsewhere undefined data
// - identifier at 9Ah (48-bit) or 98h (64-bit), elsewhere undefined
// - one pointer shared by array and extended block
// - reads past last identifier byte wrap to extended block start
// - wp low with any flag set: writes only reach 80h to FFh
`timescale 1ns/100ps
`default_nettype none
`include "eep_cfg.svh"
module eep_top
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_link_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       wp_i,
  input  wire logic       strap_pin_0_i,
  input  wire logic       strap_pin_1_i,
  input  wire logic       strap_pin_2_i,
  input  wire logic       high_voltage_level_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o
);
  eep_pkg::eep_link_s q;
  eep_pkg::eep_link_s n;
  eep_pkg::eep_sys_s  sq;
  eep_pkg::eep_sys_s  sn;
  eep_pkg::eep_pins_s p;
  logic [7:0]         raw_pins;
  logic [7:0]         sync_pins;
  logic [2:0]         st_sync;
  logic [7:0]         rd_dat;
  logic [7:0]         rd_byte;
  logic [7:0]         nxt_ptr;
  logic               rise;
  logic               fall;
  logic               start;
  logic               stop;
  logic               rx_st;
  logic               done;
  logic               sel_me;
  logic               is_rev;
  logic               is_clr;
  logic               wr_ok;

  // pins and the variant bit into the link domain
  assign raw_pins = {scl_i, sda_i, wp_i, strap_pin_2_i, strap_pin_1_i,
                     strap_pin_0_i, high_voltage_level_i,
                     sq.ctrl[`EEP_CTRL_V64]};

  eep_sync #(
    .W (8)
  ) u_sync_link (
    .clk_i   (clk_link_i),
    .rst_n_i (rst_n_i),
    .d_i     (raw_pins),
    .q_o     (sync_pins)
  );

  assign p = eep_pkg::eep_pins_s'(sync_pins);

  // flags and wp level into the system domain
  eep_sync #(
    .W (3)
  ) u_sync_sys (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     ({wp_i, q.rflag, q.pflag}),
    .q_o     (st_sync)
  );

  eep_store u_store (
    .clk_i   (clk_link_i),
    .rst_n_i (rst_n_i),
    .wr_i    (q.wr),
    .waddr_i (q.waddr),
    .wdat_i  (q.wdat),
    .ext_i   (q.kind == eep_pkg::EEP_K_EXT),
    .v64_i   (p.v64),
    .addr_i  (q.ptr),
    .rdat_o  (rd_dat)
  );

  // bus conditions seen on the sampled pins
  assign rise  = p.scl & ~q.scl_q;
  assign fall  = ~p.scl & q.scl_q;
  assign start = p.scl & q.scl_q & q.sda_q & ~p.sda;
  assign stop  = p.scl & q.scl_q & ~q.sda_q & p.sda;
  assign rx_st = q.st == eep_pkg::EEP_ADDR || q.st == eep_pkg::EEP_WORD ||
                 q.st == eep_pkg::EEP_DATA;
  assign done  = fall && q.bitc == `EEP_BITS;

  // address byte decode
  assign sel_me  = q.sh[3:1] == p.strap;
  assign is_rev  = q.sh[3:1] == `EEP_SEL_REV && p.hv;
  assign is_clr  = q.sh[3:1] == `EEP_SEL_CLR && p.hv && !q.sh[0];

  // protection query data is undefined
  assign rd_byte = (q.kind == eep_pkg::EEP_K_PROT) ? `EEP_UNDEF : rd_dat;

  // pointer advance, extended block wraps to its start
  assign nxt_ptr = (q.kind == eep_pkg::EEP_K_EXT && q.ptr == `EEP_EXT_LAST) ?
                   `EEP_SER_BASE : q.ptr + 8'h01;

  // array write gate by wp pin and protection flags
  assign wr_ok = !p.wp && (!(q.pflag || q.rflag) || q.ptr >= `EEP_UPPER_BASE);

  // link state machine, one step per link clock
  always_comb
  begin
    n       = q;
    n.scl_q = p.scl;
    n.sda_q = p.sda;
    n.wr    = 1'b0;
    if (rx_st && rise)
    begin
      n.sh   = {q.sh[6:0], p.sda};
      n.bitc = q.bitc + 4'h1;
    end
    if (start)
    begin
      n.st   = eep_pkg::EEP_ADDR;
      n.bitc = 4'h0;
      n.oe   = 1'b0;
    end
    else if (stop)
    begin
      n.st = eep_pkg::EEP_IDLE;
      n.oe = 1'b0;
    end
    else
    begin
      unique case (q.st)
        eep_pkg::EEP_IDLE:
          n.oe = 1'b0;
        eep_pkg::EEP_ADDR:
        begin
          if (done)
          begin
            n.rd   = q.sh[0];
            n.bitc = 4'h0;
            n.st   = eep_pkg::EEP_AACK;
            n.oe   = 1'b0;
            if (q.sh[7:4] == `EEP_PRE_ARRAY && sel_me)
            begin
              n.kind = eep_pkg::EEP_K_ARRAY;
              n.oe   = 1'b1;
            end
            else if (q.sh[7:4] == `EEP_PRE_EXT && sel_me)
            begin
              n.kind = eep_pkg::EEP_K_EXT;
              n.oe   = 1'b1;
            end
            else if (q.sh[7:4] == `EEP_PRE_PROT)
            begin
              n.kind = eep_pkg::EEP_K_PROT;
              if (is_rev)
              begin
                n.oe = ~q.rflag;
                if (!q.sh[0] && !q.rflag && !p.wp)
                  n.rflag = 1'b1;
              end
              else if (is_clr)
              begin
                n.oe = ~q.pflag;
                if (!q.pflag && !p.wp)
                  n.rflag = 1'b0;
              end
              else if (sel_me)
              begin
                n.oe = ~q.pflag;
                if (!q.sh[0] && !q.pflag && !p.wp)
                  n.pflag = 1'b1;
              end
            end
            // no acknowledge: stay off the bus until the next start
            if (!n.oe)
              n.st = eep_pkg::EEP_IDLE;
          end
        end
        eep_pkg::EEP_AACK:
        begin
          if (fall)
          begin
            n.bitc = 4'h0;
            if (q.rd)
            begin
              n.sh = rd_byte;
              n.oe = ~rd_byte[7];
              n.st = eep_pkg::EEP_SEND;
            end
            else
            begin
              n.oe = 1'b0;
              n.st = eep_pkg::EEP_WORD;
            end
          end
        end
        eep_pkg::EEP_WORD:
        begin
          if (done)
          begin
            n.bitc = 4'h0;
            n.oe   = 1'b1;
            n.st   = eep_pkg::EEP_WACK;
            if (q.kind != eep_pkg::EEP_K_PROT)
              n.ptr = q.sh;
          end
        end
        eep_pkg::EEP_WACK:
        begin
          if (fall)
          begin
            n.oe = 1'b0;
            n.st = eep_pkg::EEP_DATA;
          end
        end
        eep_pkg::EEP_DATA:
        begin
          if (done)
          begin
            n.bitc = 4'h0;
            n.oe   = 1'b1;
            n.st   = eep_pkg::EEP_DACK;
            if (q.kind != eep_pkg::EEP_K_PROT)
              n.ptr = nxt_ptr;
            if (q.kind == eep_pkg::EEP_K_ARRAY && wr_ok)
            begin
              n.wr    = 1'b1;
              n.waddr = q.ptr;
              n.wdat  = q.sh;
            end
          end
        end
        eep_pkg::EEP_DACK:
        begin
          if (fall)
          begin
            n.oe = 1'b0;
            n.st = eep_pkg::EEP_DATA;
          end
        end
        eep_pkg::EEP_SEND:
        begin
          if (rise)
            n.bitc = q.bitc + 4'h1;
          else if (done)
          begin
            n.oe = 1'b0;
            n.st = eep_pkg::EEP_MACK;
            if (q.kind != eep_pkg::EEP_K_PROT)
              n.ptr = nxt_ptr;
          end
          else if (fall)
          begin
            n.sh = {q.sh[6:0], 1'b1};
            n.oe = ~q.sh[6];
          end
        end
        eep_pkg::EEP_MACK:
        begin
          if (rise)
            n.mack = ~p.sda;
          else if (fall)
          begin
            n.bitc = 4'h0;
            if (q.mack)
            begin
              n.sh = rd_byte;
              n.oe = ~rd_byte[7];
              n.st = eep_pkg::EEP_SEND;
            end
            else
            begin
              n.oe = 1'b0;
              n.st = eep_pkg::EEP_IDLE;
            end
          end
        end
        default:
        begin
          n.st = eep_pkg::EEP_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
  end

  // link state register
  always_ff @(posedge clk_link_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q       <= '0;
      q.st    <= eep_pkg::EEP_IDLE;
      q.kind  <= eep_pkg::EEP_K_ARRAY;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
    end
    else
      q <= n;
  end

  // register port: control write, status and control read
  always_comb
  begin
    sn       = sq;
    sn.rdata = 8'h00;
    if (reg_wr_i && reg_addr_i == `EEP_REG_CTRL)
      sn.ctrl = reg_wdata_i;
    if (reg_rd_i)
    begin
      if (reg_addr_i == `EEP_REG_STATUS)
      begin
        sn.rdata[`EEP_ST_PFLAG] = st_sync[0];
        sn.rdata[`EEP_ST_RFLAG] = st_sync[1];
        sn.rdata[`EEP_ST_WP]    = st_sync[2];
      end
      else if (reg_addr_i == `EEP_REG_CTRL)
        sn.rdata = sq.ctrl;
    end
  end

  // system state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sq.ctrl  <= `EEP_CTRL_RST;
      sq.rdata <= 8'h00;
    end
    else
      sq <= sn;
  end

  // open-drain data pin: drive low only
  assign sda_o       = 1'b0;
  assign sda_oe_o    = q.oe;
  assign reg_rdata_o = sq.rdata;
endmodule : eep_top
`default_nettype wire

/* eep_mst.sv */
// eep_mst: bit-level two-wire bus master model
`timescale 1ns/100ps
`default_nettype none
module eep_mst
(
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  // idle bus: clock high, data released
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : w
  // start or repeated start; ends with clock low
  task automatic start();
    sda_low_o <= 1'b0;
    w(8);
    scl_o <= 1'b1;
    w(8);
    sda_low_o <= 1'b1;
    w(8);
    scl_o <= 1'b0;
  endtask : start
  // stop, bus left idle
  task automatic stop();
    w(8);
    sda_low_o <= 1'b1;
    w(8);
    scl_o <= 1'b1;
    w(8);
    sda_low_o <= 1'b0;
    w(8);
  endtask : stop
  // one bit: data set mid-low, line sampled mid-high
  task automatic bit1(input logic b, output logic s);
    w(8);
    sda_low_o <= !b;
    w(8);
    scl_o <= 1'b1;
    w(8);
    s = sda_i;
    w(8);
    scl_o <= 1'b0;
  endtask : bit1
  // byte msb first, then ninth bit b9 (1 releases the line)
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                      output logic s9);
    for (int i = 7; i >= 0; i--)
      bit1(d[i], q[i]);
    bit1(b9, s9);
  endtask : xfer
endmodule : eep_mst
`default_nettype wire

/* eep_top_sva.sv */
// eep_top_sva: port checks of the eeprom block
`timescale 1ns/100ps
`default_nettype none
module eep_top_sva
(
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       clk_link_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       wp_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  // register strobes
  sequence s_stat_rd;
    reg_rd_i && !reg_wr_i && reg_addr_i == 4'h0;
  endsequence
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == 4'h4;
  endsequence
  sequence s_ctrl_rd;
    reg_rd_i && reg_addr_i == 4'h4;
  endsequence
  // stop: data rises while clock high
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  property p_open_drain;
    @(posedge clk_link_i) disable iff (!rst_n_i) sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_oe_scl_low;
    @(posedge clk_link_i) disable iff (!rst_n_i) $changed(sda_oe_o) |-> !scl_i && !$past(scl_i);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
  property p_stop_release;
    @(posedge clk_link_i) disable iff (!rst_n_i) s_stop |-> !sda_oe_o [*8];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("line held after stop");
  property p_idle_rdata;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside slot");
  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i != 4'h0 && reg_addr_i != 4'h4 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_rb;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_ctrl_wr ##1 s_ctrl_rd |=> reg_rdata_o[0] == $past(reg_wdata_i[0], 2);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("variant bit lost");
  property p_wp_st;
    @(posedge clk_sys_i) disable iff (!rst_n_i) wp_i [*4] ##0 s_stat_rd |=> reg_rdata_o[2];
  endproperty
  a_wp_st: assert property (p_wp_st) else $error("protect pin high not seen");
  property p_nwp_st;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !wp_i [*4] ##0 s_stat_rd |=> !reg_rdata_o[2];
  endproperty
  a_nwp_st: assert property (p_nwp_st) else $error("protect pin low not seen");
endmodule : eep_top_sva
bind eep_top eep_top_sva eep_top_sva_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .clk_link_i(clk_link_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wp_i(wp_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

/* eep_top_tb.sv */
// eep_top_tb: self-checking bench of the eeprom block
`timescale 1ns/100ps
`default_nettype none
`include "eep_cfg.svh"
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
module eep_top_tb;
  logic        clk_sys_i;
  logic        clk_link_i;
  logic        rst_n_i;
  logic        wp_i;
  logic        hv;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        sda_o;
  logic        sda_oe_o;
  logic        scl;
  logic        sda_low;
  wire         sda_w;
  int          fails;
  int          n_tests;
  logic [31:0] rows [5];
  // open-drain data line with pull-up
  assign sda_w = !(sda_oe_o && !sda_o) && !sda_low;
  eep_top eep_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
    .strap_pin_0_i(1'b1), .strap_pin_1_i(1'b0), .strap_pin_2_i(1'b1),
    .high_voltage_level_i(hv), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  eep_mst mst_i (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  // clocks
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    clk_link_i = 1'b0;
    #3;
    forever #15 clk_link_i = ~clk_link_i;
  end
  task automatic final_report();
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // register write and checked read
  task automatic rw(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : rw
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    // read data stands until this edge updates it
    @(posedge clk_sys_i);
    `CHK("reg", e, reg_rdata_o)
  endtask : rchk
  // byte to the device, acknowledge e expected
  task automatic sb(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic       s;
    mst_i.xfer(d, 1'b1, q, s);
    `CHK("ack", e, !s)
  endtask : sb
  // byte from the device; m9 low acknowledges
  task automatic rb(input logic [7:0] e, input logic m9);
    logic [7:0] q;
    logic       s;
    mst_i.xfer(8'hff, m9, q, s);
    `CHK("data", e, q)
  endtask : rb
  task automatic cmd(input logic [7:0] d, input logic e);
    mst_i.start();
    sb(d, e);
    mst_i.stop();
  endtask : cmd
  task automatic wr(input logic [7:0] dv, input logic [7:0] a, input logic [7:0] d0,
                    input logic [7:0] d1);
    mst_i.start();
    sb(dv, 1'b1);
    sb(a, 1'b1);
    sb(d0, 1'b1);
    sb(d1, 1'b1);
    mst_i.stop();
  endtask : wr
  // dummy write, repeated start, two bytes read
  task automatic rrd(input logic [7:0] dv, input logic [7:0] a, input logic [7:0] e0,
                     input logic [7:0] e1);
    mst_i.start();
    sb({dv[7:1], 1'b0}, 1'b1);
    sb(a, 1'b1);
    mst_i.start();
    sb({dv[7:1], 1'b1}, 1'b1);
    rb(e0, 1'b0);
    rb(e1, 1'b1);
    mst_i.stop();
  endtask : rrd
  // watchdog, about 1.6 times the expected run
  initial
  begin
    #1_000_000;
    fails++;
    final_report();
  end
  initial
  begin
    rst_n_i     = 1'b0;
    wp_i        = 1'b0;
    hv          = 1'b0;
    reg_addr_i  = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    fails       = 0;
    n_tests     = 0;
    rows = '{32'haa10_3344, 32'haaff_1122, 32'hba80_dadb, 32'hba9a_a6a7, 32'hba9f_a3da};
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h00);
    wr(8'haa, 8'h10, 8'h33, 8'h44);
    wr(8'haa, 8'hff, 8'h11, 8'h22);
    // array, wrap, serial, identifier, extended wrap
    foreach (rows[k])
      rrd(rows[k][31:24], rows[k][23:16], rows[k][15:8], rows[k][7:0]);
    mst_i.start();
    sb(8'hbb, 1'b1);
    rb(8'hdb, 1'b1);
    mst_i.stop();
    // whole serial number read from the block start
    mst_i.start();
    sb(8'hba, 1'b1);
    sb(`EEP_SER_BASE, 1'b1);
    mst_i.start();
    sb(8'hbb, 1'b1);
    for (int i = 0; i < 16; i++)
      rb(`EEP_SER_SEED ^ (`EEP_SER_BASE + 8'(i)), i == 15);
    mst_i.stop();
    // protect pin high: commands acked, nothing changes
    wp_i <= 1'b1;
    wr(8'haa, 8'h20, 8'h55, 8'h66);
    rrd(8'haa, 8'h20, 8'hff, 8'hff);
    cmd(8'h6a, 1'b1);
    hv <= 1'b1;
    cmd(8'h62, 1'b1);
    cmd(8'h66, 1'b1);
    hv <= 1'b0;
    rchk(4'h0, 8'h04);
    // protect pin low: flags set, queried and refused
    wp_i <= 1'b0;
    cmd(8'h6b, 1'b1);
    hv <= 1'b1;
    cmd(8'h62, 1'b1);
    cmd(8'h63, 1'b0);
    cmd(8'h62, 1'b0);
    hv <= 1'b0;
    wr(8'haa, 8'h10, 8'h77, 8'h78);
    wr(8'haa, 8'h90, 8'h12, 8'h34);
    rrd(8'haa, 8'h10, 8'h33, 8'h44);
    rrd(8'haa, 8'h90, 8'h12, 8'h34);
    rchk(4'h0, 8'h02);
    hv <= 1'b1;
    cmd(8'h66, 1'b1);
    hv <= 1'b0;
    cmd(8'h6a, 1'b1);
    cmd(8'h6a, 1'b0);
    cmd(8'h6b, 1'b0);
    cmd(8'h69, 1'b0);
    hv <= 1'b1;
    cmd(8'h66, 1'b0);
    hv <= 1'b0;
    rchk(4'h0, 8'h01);
    // 64-bit identifier variant, unmapped offset
    rw(4'h4, 8'h01);
    rchk(4'h4, 8'h01);
    rrd(8'hba, 8'h98, 8'ha4, 8'ha5);
    rchk(4'h8, 8'h00);
    // mid-run reset: flags, control and pointer back to reset values
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h00);
    mst_i.start();
    sb(8'hab, 1'b1);
    rb(`EEP_MEM_RST, 1'b1);
    mst_i.stop();
    final_report();
  end
endmodule : eep_top_tb
`default_nettype wire
